/* File: core/ccss_clock_select.sv */
// clock source selection for the dsp, dac, oversample and charge pump dividers
`timescale 1ns/1ns
module ccss_clock_select #(
  parameter int ADDR_W = 8
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  // register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  // candidate sources
  input ccss_pkg::ccss_src_s srcIn,
  input wire logic generalPinZero,
  input wire logic generalPinTwo,
  // divider inputs and the master-on-oscillator flag
  output ccss_pkg::ccss_div_s divClk,
  output ccss_pkg::ccss_div_s divMuted,
  output logic masterOnOsc
);

  // ==========================================================================
  // parameter check
  if (ADDR_W < 7 || ADDR_W > 8) begin : gAddrCheck
    $error("ccss_clock_select: ADDR_W must be 7 or 8");
  end

  // ==========================================================================
  // configuration registers
  logic [2:0] dspSourceSel_r;
  logic [2:0] dacSourceSel_r;
  logic [2:0] oversampleSourceSel_r;
  logic [2:0] chargePumpSourceSel_r;
  logic [2:0] dspPinSel_r;
  logic [2:0] dacPinSel_r;
  logic [2:0] chargePumpPinSel_r;
  logic [2:0] oversamplePinSel_r;
  logic [7:0] regRdData_r;
  ccss_pkg::ccss_div_s divClk_r;
  ccss_pkg::ccss_div_s divMuted_r;
  logic masterOnOsc_r;

  wire logic [7:0] addr8 = 8'(regAddr);
  wire logic hitDsp = (addr8 == ccss_pkg::DSP_SRC_OFS);
  wire logic hitDacOsr = (addr8 == ccss_pkg::DAC_OSR_SRC_OFS);
  wire logic hitCp = (addr8 == ccss_pkg::CP_SRC_OFS);
  wire logic hitDspDacPin = (addr8 == ccss_pkg::DSP_DAC_PIN_OFS);
  wire logic hitCpOsrPin = (addr8 == ccss_pkg::CP_OSR_PIN_OFS);
  wire logic hitStatus = (addr8 == ccss_pkg::STATUS_OFS);

  wire logic [2:0] wrHi = regWrData[ccss_pkg::HI_FIELD_LSB +: 3];
  wire logic [2:0] wrLo = regWrData[ccss_pkg::LO_FIELD_LSB +: 3];

  // reserved bits are not stored and read back as zero
  function automatic logic [7:0] packFields(input logic [2:0] hi, input logic [2:0] lo);
    packFields = {1'b0, hi, 1'b0, lo};
  endfunction : packFields

  // reset waits for the enable as well, so a frozen block keeps every field
  always_ff @(posedge ref_clk) begin
    if (rst && clkEn) begin
      dspSourceSel_r <= ccss_pkg::FIELD_RESET;
      dacSourceSel_r <= ccss_pkg::FIELD_RESET;
      oversampleSourceSel_r <= ccss_pkg::FIELD_RESET;
      chargePumpSourceSel_r <= ccss_pkg::FIELD_RESET;
      dspPinSel_r <= ccss_pkg::FIELD_RESET;
      dacPinSel_r <= ccss_pkg::FIELD_RESET;
      chargePumpPinSel_r <= ccss_pkg::FIELD_RESET;
      oversamplePinSel_r <= ccss_pkg::FIELD_RESET;
    end else if (clkEn && regWrEn) begin
      if (hitDsp) begin
        dspSourceSel_r <= wrLo;
      end else if (hitDacOsr) begin
        dacSourceSel_r <= wrHi;
        oversampleSourceSel_r <= wrLo;
      end else if (hitCp) begin
        chargePumpSourceSel_r <= wrLo;
      end else if (hitDspDacPin) begin
        dspPinSel_r <= wrHi;
        dacPinSel_r <= wrLo;
      end else if (hitCpOsrPin) begin
        chargePumpPinSel_r <= wrHi;
        oversamplePinSel_r <= wrLo;
      end
    end
  end

  // ==========================================================================
  // pin pickers
  logic dspPinClk;
  logic dacPinClk;
  logic cpPinClk;
  logic osrPinClk;
  logic dspPinOk;
  logic dacPinOk;
  logic cpPinOk;
  logic osrPinOk;

  ccss_pin_pick uDspPin (
    .pinSel(dspPinSel_r),
    .generalPinZero(generalPinZero),
    .generalPinTwo(generalPinTwo),
    .pinClk(dspPinClk),
    .pinValid(dspPinOk)
  );

  ccss_pin_pick uDacPin (
    .pinSel(dacPinSel_r),
    .generalPinZero(generalPinZero),
    .generalPinTwo(generalPinTwo),
    .pinClk(dacPinClk),
    .pinValid(dacPinOk)
  );

  ccss_pin_pick uCpPin (
    .pinSel(chargePumpPinSel_r),
    .generalPinZero(generalPinZero),
    .generalPinTwo(generalPinTwo),
    .pinClk(cpPinClk),
    .pinValid(cpPinOk)
  );

  ccss_pin_pick uOsrPin (
    .pinSel(oversamplePinSel_r),
    .generalPinZero(generalPinZero),
    .generalPinTwo(generalPinTwo),
    .pinClk(osrPinClk),
    .pinValid(osrPinOk)
  );

  // ==========================================================================
  // master clock auto-select
  wire logic masterClk = srcIn.pllPathValid ? srcIn.pllClk : srcIn.oscClk;

  // dac-style table, result is {muted, clock}
  function automatic logic [1:0] pickDacTable(input logic [2:0] code,
                                               input ccss_pkg::ccss_src_s s,
                                               input logic master,
                                               input logic pinClk,
                                               input logic pinOk);
    pickDacTable = 2'h2;
    case (code)
      ccss_pkg::DSRC_MASTER: pickDacTable = {1'b0, master};
      ccss_pkg::DSRC_PLL: pickDacTable = {1'b0, s.pllClk};
      ccss_pkg::DSRC_OSC: pickDacTable = {1'b0, s.oscClk};
      ccss_pkg::DSRC_MCLK: pickDacTable = {1'b0, s.mclkPin};
      ccss_pkg::DSRC_BCLK: pickDacTable = {1'b0, s.bitClk};
      ccss_pkg::DSRC_PIN: pickDacTable = {~pinOk, pinClk};
      default: pickDacTable = 2'h2;
    endcase
  endfunction : pickDacTable

  // oversample-style table, code 000 takes the dac divider input
  function automatic logic [1:0] pickOsrTable(input logic [2:0] code,
                                               input ccss_pkg::ccss_src_s s,
                                               input logic master,
                                               input logic [1:0] dacPick,
                                               input logic pinClk,
                                               input logic pinOk);
    pickOsrTable = 2'h2;
    case (code)
      ccss_pkg::OSRC_DAC: pickOsrTable = dacPick;
      ccss_pkg::OSRC_MASTER: pickOsrTable = {1'b0, master};
      ccss_pkg::OSRC_PLL: pickOsrTable = {1'b0, s.pllClk};
      ccss_pkg::OSRC_OSC: pickOsrTable = {1'b0, s.oscClk};
      ccss_pkg::OSRC_MCLK: pickOsrTable = {1'b0, s.mclkPin};
      ccss_pkg::OSRC_BCLK: pickOsrTable = {1'b0, s.bitClk};
      ccss_pkg::OSRC_PIN: pickOsrTable = {~pinOk, pinClk};
      default: pickOsrTable = 2'h2;
    endcase
  endfunction : pickOsrTable

  wire logic [1:0] dspPick = pickDacTable(dspSourceSel_r, srcIn, masterClk,
                                          dspPinClk, dspPinOk);
  wire logic [1:0] dacPick = pickDacTable(dacSourceSel_r, srcIn, masterClk,
                                          dacPinClk, dacPinOk);
  wire logic [1:0] osrPick = pickOsrTable(oversampleSourceSel_r, srcIn, masterClk,
                                          dacPick, osrPinClk, osrPinOk);
  wire logic [1:0] cpPick = pickOsrTable(chargePumpSourceSel_r, srcIn, masterClk,
                                         dacPick, cpPinClk, cpPinOk);

  // muted inputs hold low
  wire ccss_pkg::ccss_div_s clkNxt = '{dsp: dspPick[0] & ~dspPick[1],
                                      dac: dacPick[0] & ~dacPick[1],
                                      osr: osrPick[0] & ~osrPick[1],
                                      cp: cpPick[0] & ~cpPick[1]};
  wire ccss_pkg::ccss_div_s mutedNxt = '{dsp: dspPick[1],
                                        dac: dacPick[1],
                                        osr: osrPick[1],
                                        cp: cpPick[1]};

  // ==========================================================================
  // read data
  wire logic [7:0] statusWord = {3'h0, ~srcIn.pllPathValid, divMuted_r};
  wire logic [7:0] rdNxt =
    hitDsp ? packFields(3'h0, dspSourceSel_r) :
    hitDacOsr ? packFields(dacSourceSel_r, oversampleSourceSel_r) :
    hitCp ? packFields(3'h0, chargePumpSourceSel_r) :
    hitDspDacPin ? packFields(dspPinSel_r, dacPinSel_r) :
    hitCpOsrPin ? packFields(chargePumpPinSel_r, oversamplePinSel_r) :
    hitStatus ? statusWord : 8'h00;

  always_ff @(posedge ref_clk) begin
    // held enable also holds off reset of the outputs and read data
    if (rst && clkEn) begin
      divClk_r <= '0;
      divMuted_r <= '0;
      masterOnOsc_r <= 1'b0;
      regRdData_r <= ccss_pkg::RD_RESET;
    end else if (clkEn) begin
      divClk_r <= clkNxt;
      divMuted_r <= mutedNxt;
      masterOnOsc_r <= ~srcIn.pllPathValid;
      if (regRdEn) begin
        regRdData_r <= rdNxt;
      end
    end
  end

  assign divClk = divClk_r;
  assign divMuted = divMuted_r;
  assign masterOnOsc = masterOnOsc_r;
  assign regRdData = regRdData_r;

endmodule : ccss_clock_select

/* File: core/ccss_pkg.sv */
// constants and carrier types for the converter clock source selector
package ccss_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] DSP_SRC_OFS = 8'h0d;
  localparam logic [7:0] DAC_OSR_SRC_OFS = 8'h0e;
  localparam logic [7:0] CP_SRC_OFS = 8'h0f;
  localparam logic [7:0] DSP_DAC_PIN_OFS = 8'h10;
  localparam logic [7:0] CP_OSR_PIN_OFS = 8'h11;
  localparam logic [7:0] STATUS_OFS = 8'h7e;

  // ==========================================================================
  // field positions and reset values
  localparam int HI_FIELD_LSB = 4;
  localparam int LO_FIELD_LSB = 0;
  localparam logic [2:0] FIELD_RESET = 3'h0;
  localparam logic [7:0] RD_RESET = 8'h00;

  // ==========================================================================
  // dac / dsp source codes
  localparam logic [2:0] DSRC_MASTER = 3'h0;
  localparam logic [2:0] DSRC_PLL = 3'h1;
  localparam logic [2:0] DSRC_OSC = 3'h2;
  localparam logic [2:0] DSRC_MCLK = 3'h3;
  localparam logic [2:0] DSRC_BCLK = 3'h4;
  localparam logic [2:0] DSRC_PIN = 3'h5;

  // oversample / charge pump source codes
  localparam logic [2:0] OSRC_DAC = 3'h0;
  localparam logic [2:0] OSRC_MASTER = 3'h1;
  localparam logic [2:0] OSRC_PLL = 3'h2;
  localparam logic [2:0] OSRC_OSC = 3'h3;
  localparam logic [2:0] OSRC_MCLK = 3'h4;
  localparam logic [2:0] OSRC_BCLK = 3'h5;
  localparam logic [2:0] OSRC_PIN = 3'h6;

  // pin selector codes
  localparam logic [2:0] PIN_ZERO = 3'h3;
  localparam logic [2:0] PIN_TWO = 3'h5;

  // ==========================================================================
  // carrier types
  typedef struct packed {
    logic pllPathValid;
    logic pllClk;
    logic oscClk;
    logic mclkPin;
    logic bitClk;
  } ccss_src_s;

  typedef struct packed {
    logic dsp;
    logic dac;
    logic osr;
    logic cp;
  } ccss_div_s;

endpackage : ccss_pkg

/* File: core/ccss_pin_pick.sv */
// general pin picker for one divider's pin input
`timescale 1ns/1ns
module ccss_pin_pick (
  // selector code
  input wire logic [2:0] pinSel,
  // candidate pins
  input wire logic generalPinZero,
  input wire logic generalPinTwo,
  // result
  output logic pinClk,
  output logic pinValid
);

  wire logic pickZero = (pinSel == ccss_pkg::PIN_ZERO);
  wire logic pickTwo = (pinSel == ccss_pkg::PIN_TWO);

  // n/a and reserved codes leave the pin input muted
  assign pinValid = pickZero | pickTwo;
  assign pinClk = (pickZero & generalPinZero) | (pickTwo & generalPinTwo);

endmodule : ccss_pin_pick

/* File: bench/ccss_clock_select_sva.sv */
// port checker for the clock source selector, with its bind
`timescale 1ns/1ns
module ccss_clock_select_sva #(
  parameter int ADDR_W = 8
) (
  // clock and control
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  // register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  // sources, divider inputs and the master-on-oscillator flag
  input ccss_pkg::ccss_src_s srcIn,
  input ccss_pkg::ccss_div_s divClk,
  input ccss_pkg::ccss_div_s divMuted,
  input wire logic masterOnOsc
);
  // ==========================================================================
  // shadow of the dac / oversample source register
  logic [7:0] srcReg_r;
  wire logic [2:0] dacCode = srcReg_r[6:4];
  wire logic [2:0] osrCode = srcReg_r[2:0];
  wire logic srcWr = clkEn && regWrEn && regAddr == ADDR_W'(ccss_pkg::DAC_OSR_SRC_OFS);
  always_ff @(posedge ref_clk) begin
    if (rst && clkEn) srcReg_r <= 8'h00;
    else if (srcWr) srcReg_r <= regWrData;
  end
  // ==========================================================================
  // properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_rd_unmapped; clkEn && regRdEn && regAddr == ADDR_W'(8'h7f); endsequence
  sequence s_dac_muted; divMuted.dac && !divClk.dac; endsequence
  property p_rd_hold; !(clkEn && regRdEn) |=> $stable(regRdData); endproperty
  property p_unmapped; s_rd_unmapped |=> regRdData == 8'h00; endproperty
  property p_freeze; !clkEn |=> $stable(divClk) && $stable(divMuted); endproperty
  property p_mute_low; (divMuted & divClk) == 4'h0; endproperty
  property p_osc_flag; clkEn |=> masterOnOsc == !$past(srcIn.pllPathValid); endproperty
  property p_dac_pll;
    clkEn && dacCode == ccss_pkg::DSRC_PLL |=> divClk.dac == $past(srcIn.pllClk) && !divMuted.dac;
  endproperty
  property p_dac_mute; clkEn && dacCode > ccss_pkg::DSRC_PIN |=> s_dac_muted; endproperty
  property p_osr_dac;
    clkEn && osrCode == ccss_pkg::OSRC_DAC |=>
      divClk.osr == divClk.dac && divMuted.osr == divMuted.dac;
  endproperty
  property p_osr_master;
    clkEn && osrCode == ccss_pkg::OSRC_MASTER |=>
      divClk.osr == ($past(srcIn.pllPathValid) ? $past(srcIn.pllClk) : $past(srcIn.oscClk));
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_freeze: assert property (p_freeze) else $error("outputs moved while disabled");
  a_mute_low: assert property (p_mute_low) else $error("muted input not low");
  a_osc_flag: assert property (p_osc_flag) else $error("oscillator flag wrong");
  a_dac_pll: assert property (p_dac_pll) else $error("dac not on pll");
  a_dac_mute: assert property (p_dac_mute) else $error("dac not muted");
  a_osr_dac: assert property (p_osr_dac) else $error("oversample not on dac");
  a_osr_master: assert property (p_osr_master) else $error("oversample not on master");
endmodule : ccss_clock_select_sva

bind ccss_clock_select ccss_clock_select_sva #(.ADDR_W(ADDR_W)) i_ccss_clock_select_sva (
  .ref_clk, .rst, .clkEn, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .srcIn,
  .divClk, .divMuted, .masterOnOsc);

/* File: bench/ccss_clock_select_test.sv */
// self-checking bench for the clock source selector
`timescale 1ns/1ns
module ccss_clock_select_test;
  logic ref_clk, rst, clkEn, regWrEn, regRdEn, generalPinZero, generalPinTwo, masterOnOsc;
  logic [7:0] regAddr, regWrData, regRdData;
  ccss_pkg::ccss_src_s srcIn;
  ccss_pkg::ccss_div_s divClk, divMuted;
  int fail_count = 0;
  int checks_done = 0;
  wire logic master = srcIn.pllPathValid ? srcIn.pllClk : srcIn.oscClk;

  ccss_clock_select #(.ADDR_W(8)) i_ccss_clock_select (.ref_clk, .rst, .clkEn, .regAddr,
    .regWrData, .regWrEn, .regRdEn, .regRdData, .srcIn, .generalPinZero, .generalPinTwo,
    .divClk, .divMuted, .masterOnOsc);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    if (fail_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge ref_clk);
    #1 regWrEn = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge ref_clk);
    #1 regRdEn = 1'b0;
    q = regRdData;
    @(posedge ref_clk);
    #1;
  endtask : rd

  function automatic logic [1:0] pin(input logic [2:0] p);
    if (p == ccss_pkg::PIN_ZERO) return {1'b0, generalPinZero};
    if (p == ccss_pkg::PIN_TWO) return {1'b0, generalPinTwo};
    return 2'b10;
  endfunction : pin

  function automatic logic [1:0] dtbl(input logic [2:0] c, input logic [1:0] pr);
    case (c)
      3'h0: return {1'b0, master};
      3'h1: return {1'b0, srcIn.pllClk};
      3'h2: return {1'b0, srcIn.oscClk};
      3'h3: return {1'b0, srcIn.mclkPin};
      3'h4: return {1'b0, srcIn.bitClk};
      3'h5: return pr;
      default: return 2'b10;
    endcase
  endfunction : dtbl

  // oversample codes 1..5 are the dac codes 0..4 shifted up by one
  function automatic logic [1:0] otbl(input logic [2:0] c, input logic [1:0] dr,
                                      input logic [1:0] pr);
    if (c == 3'h0) return dr;
    if (c == 3'h6) return pr;
    if (c == 3'h7) return 2'b10;
    return dtbl(c - 3'h1, pr);
  endfunction : otbl

  task automatic regs_rw;
    logic [7:0] ofs [5] = '{8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11};
    logic [7:0] msk [5] = '{8'h07, 8'h77, 8'h07, 8'h77, 8'h77};
    logic [7:0] q;
    check({4'h0, masterOnOsc, divMuted}, 9'h000);
    rd(8'h7e, q);
    check({1'b0, q}, 9'h010);
    for (int i = 0; i < 5; i++) begin
      rd(ofs[i], q);
      check({1'b0, q}, 9'h000);
      wr(ofs[i], 8'hff);
      rd(ofs[i], q);
      check({1'b0, q}, {1'b0, msk[i]});
    end
    wr(8'h7f, 8'hff);
    rd(8'h7f, q);
    check({1'b0, q}, 9'h000);
    wr(8'h7e, 8'h00);
    rd(8'h7e, q);
    check({1'b0, q}, 9'h01f);
  endtask : regs_rw

  task automatic table_walk;
    logic [2:0] d, ph, pl;
    logic [1:0] ed, eo, ec, es;
    logic [5:0] w;
    for (int c = 0; c < 8; c++) begin
      d = 3'(c - 2);
      wr(8'h0e, {1'b0, d, 1'b0, 3'(c)});
      wr(8'h0f, {5'h00, 3'(c + 3)});
      wr(8'h0d, {5'h00, 3'(c + 1)});
      for (int p = 0; p < 3; p++) begin
        ph = 3'(2 * p + 1);
        pl = ph + 3'h2;
        wr(8'h10, {1'b0, ph, 1'b0, pl});
        wr(8'h11, {1'b0, ph, 1'b0, pl});
        for (int k = 0; k < 12; k++) begin
          w = 6'h01 << (k / 2);
          srcIn = {k[0], w[5:2]};
          {generalPinZero, generalPinTwo} = w[1:0];
          @(posedge ref_clk);
          #1;
          ed = dtbl(d, pin(pl));
          eo = otbl(3'(c), ed, pin(pl));
          ec = otbl(3'(c + 3), ed, pin(ph));
          es = dtbl(3'(c + 1), pin(ph));
          check({7'h00, divMuted.dac, divClk.dac}, {7'h00, ed});
          check({7'h00, divMuted.osr, divClk.osr}, {7'h00, eo});
          check({7'h00, divMuted.cp, divClk.cp}, {7'h00, ec});
          check({7'h00, divMuted.dsp, divClk.dsp}, {7'h00, es});
          check({8'h00, masterOnOsc}, {8'h00, ~srcIn.pllPathValid});
        end
      end
    end
  endtask : table_walk

  task automatic freeze_check;
    logic [7:0] q;
    wr(8'h0e, 8'h12);
    srcIn = 5'h18;
    @(posedge ref_clk);
    #1 clkEn = 1'b0;
    check({7'h00, divClk.dac, divClk.osr}, 9'h003);
    srcIn = 5'h00;
    rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 clkEn = 1'b1;
    rst = 1'b0;
    check({7'h00, divClk.dac, divClk.osr}, 9'h003);
    @(posedge ref_clk);
    #1;
    check({7'h00, divClk.dac, divClk.osr}, 9'h000);
    rd(8'h0e, q);
    check({1'b0, q}, 9'h012);
  endtask : freeze_check

  initial begin
    rst = 1'b1;
    clkEn = 1'b1;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    srcIn = '0;
    generalPinZero = 1'b0;
    generalPinTwo = 1'b0;
    repeat (16) @(posedge ref_clk);
    #1 rst = 1'b0;
    regs_rw();
    table_walk();
    freeze_check();
    tally_and_finish();
  end
endmodule : ccss_clock_select_test
